// File: test/host_model.sv
// host processor model driving the watchdog strobe
// assumes clk_i is the supervisor clock
`timescale 1ns/100ps
module host_model (
  // control
  input  wire logic clk_i,
  input  wire logic run_i,
  // strobe
  output logic      strobe_o
);
  logic [1:0] cnt_r = 2'b00;
  initial strobe_o = 1'b0;
  // an edge every third cycle while running; a stall holds the line still
  always @(posedge clk_i)
  begin
    cnt_r <= (cnt_r == 2'd2) ? 2'd0 : cnt_r + 2'd1;
    if (run_i && cnt_r == 2'd2)
      strobe_o <= #1 ~strobe_o;
  end
endmodule : host_model

// File: test/reset_watchdog_supervisor_tb.sv
// self-checking bench of the reset and watchdog supervisor
// assumes host_model on the strobe; table times divided by 1000
`timescale 1ns/100ps
module reset_watchdog_supervisor_tb;
  import supervisor_pkg::*;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic [7:0]              addr  = 8'h00;
  logic [7:0]              wdata = 8'h00;
  logic                    wr_s  = 1'b0;
  logic                    rd_s  = 1'b0;
  logic                    sup   = 1'b0;
  logic                    en    = 1'b0;
  logic                    run   = 1'b0;
  logic                    sr    = 1'b0;
  logic                    mr_n  = 1'b1;
  logic [NUM_CHANNELS-1:0] uv    = '0;
  logic [NUM_CHANNELS-1:0] ov    = '0;
  logic [NUM_CHANNELS-1:0] ew    = '0;
  logic [NUM_CHANNELS-1:0] crit  = '0;
  logic [7:0]              ra [4] = '{8'h3B, 8'h3C, 8'h3D, 8'h55};
  logic [7:0]              rdata, d, r;
  logic                    pin_o, oe, asr, wdf_n, strobe;
  logic [11:0]             sel;
  int                      n, error_cnt = 0, cmp_count = 0;
  // pin level as the board sees it, pull-up when released
  wire logic [7:0]         pin = {6'h00, oe, oe ? pin_o : 1'b1};

  // one tick per cycle keeps the hold and watchdog times short
  reset_watchdog_supervisor #(.TICK_CYCLES(1), .TIME_DIV(1000)) reset_watchdog_supervisor_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .supply_ok_i(sup), .boot_done_i(sup),
    .soft_reboot_i(sr), .enable_i(en), .manual_reset_input_n_i(mr_n),
    .watchdog_strobe_input_i(strobe), .uv_viol_i(uv), .ov_viol_i(ov), .ew_viol_i(ew),
    .critical_fault_i(crit), .reset_o(pin_o), .reset_oe_o(oe), .reset_asserted_o(asr),
    .watchdog_fault_output_n_o(wdf_n));
  host_model host_model_i (.clk_i(clk_i), .run_i(run), .strobe_o(strobe));

  always #10 clk_i = ~clk_i;

  // comparison, register access and wait helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i) #1;
    addr = a;
    wdata = v;
    wr_s = 1'b1;
    @(posedge clk_i) #1;
    wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i) #1;
    addr = a;
    rd_s = 1'b1;
    @(posedge clk_i) #1;
    rd_s = 1'b0;
    d = rdata;
  endtask : rd
  // bounded wait; running out of cycles ends the run
  task automatic wait_on(input bit wd, input logic v, input int lim);
    for (int i = 0; i < lim && (wd ? wdf_n : asr) !== v; i++)
      @(posedge clk_i) #1;
    chk({7'h0, wd ? wdf_n : asr}, {7'h0, v});
    if ((wd ? wdf_n : asr) !== v)
      give_verdict();
  endtask : wait_on
  task automatic stay(input bit wd, input logic v, input int lim);
    logic ok;
    ok = 1'b1;
    repeat (lim)
    begin
      @(posedge clk_i) #1;
      ok &= ((wd ? wdf_n : asr) === v);
    end
    chk({7'h0, ok}, 8'h01);
  endtask : stay
  // kind 0 undervoltage, 1 early warning, 2 overvoltage, 3 none
  task automatic viol(input int k, input logic [11:0] m);
    uv = (k == 0) ? m : '0;
    ew = (k == 1) ? m : '0;
    ov = (k == 2) ? m : '0;
  endtask : viol
  // pd is {drive, polarity}; open drain only pulls the pin low
  function automatic logic [7:0] exp_pin(input logic a, input logic [1:0] pd);
    logic lvl;
    lvl = a ? pd[0] : ~pd[0];
    return {6'h00, pd[1] | ~lvl, lvl};
  endfunction : exp_pin
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // main sequence
  initial
  begin
    void'($urandom(52));
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    sup = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      rd(ra[k]);
      chk(d, 8'h00);
    end
    wait_on(0, 1'b0, 100);
    r = 8'($urandom);
    wr(8'h3D, r);
    rd(8'h3D);
    chk(d, r & 8'h1F);
    wr(8'h55, r);
    rd(8'h55);
    chk(d, 8'h00);
    wr(8'h3B, r);
    rd(8'h3B);
    chk(d, r);
    $display("test 1 done");
    // each class: wrong kind and unselected channel stay quiet
    for (int c = 0; c < 4; c++)
    begin
      sel = 12'h001 << $urandom_range(11);
      wr(8'h3B, {6'h00, 2'(c)});
      wr(8'h3C, {sel[6:0], 1'b0});
      wr(8'h3D, {3'h0, sel[11:7]});
      viol(c == 0 ? 2 : c == 3 ? 1 : 0, sel);
      stay(0, 1'b0, 6);
      viol(c == 3 ? 2 * $urandom_range(1) : c, {sel[10:0], sel[11]});
      stay(0, 1'b0, 6);
      viol(c == 3 ? 2 * $urandom_range(1) : c, sel);
      wait_on(0, 1'b1, 5);
      chk(pin, exp_pin(1'b1, 2'b00));
      viol(3, sel);
      wait_on(0, 1'b0, 10);
    end
    wr(8'h3C, 8'h00);
    wr(8'h3D, 8'h00);
    crit = 12'h001 << $urandom_range(11);
    wait_on(0, 1'b1, 5);
    crit = '0;
    wait_on(0, 1'b0, 10);
    // manual reset pin and software reboot are reset events too
    mr_n = 1'b0;
    wait_on(0, 1'b1, 5);
    mr_n = 1'b1;
    wait_on(0, 1'b0, 10);
    sr = 1'b1;
    @(posedge clk_i) #1;
    sr = 1'b0;
    wait_on(0, 1'b1, 5);
    wait_on(0, 1'b0, 10);
    $display("test 2 done");
    // force and hold over every polarity and drive type, 60 tick hold
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h3B, {4'h9, 2'(p), 2'b00});
      @(posedge clk_i) #1; // pin registers follow the config one cycle later
      chk(pin, exp_pin(1'b0, 2'(p)));
      wr(8'h3C, 8'h01);
      wait_on(0, 1'b1, 5);
      chk(pin, exp_pin(1'b1, 2'(p)));
      wr(8'h3C, 8'h00);
      for (n = 0; n < 200 && asr === 1'b1; n++)
        @(posedge clk_i) #1;
      chk({7'h0, n >= 57 && n <= 64}, 8'h01);
    end
    $display("test 3 done");
    // dependent watchdog, 8 tick timeout
    wr(8'h76, 8'h04);
    en = 1'b1;
    run = 1'b1;
    stay(1, 1'b1, 60);
    run = 1'b0;
    wait_on(1, 1'b0, 30);
    run = 1'b1;
    wait_on(1, 1'b1, 10);
    en = 1'b0;
    run = 1'b0;
    stay(1, 1'b1, 40);
    en = 1'b1;
    wr(8'h3C, 8'h01);
    stay(1, 1'b1, 40);
    wr(8'h3C, 8'h00);
    // enable low then high restarts a long startup delay
    wr(8'h76, 8'h14);
    en = 1'b0;
    repeat (4) @(posedge clk_i) #1;
    en = 1'b1;
    stay(1, 1'b1, 1000);
    $display("test 4 done");
    // independent mode ignores enable and may pull reset
    en = 1'b0;
    wr(8'h76, 8'h84);
    wr(8'h73, 8'h10);
    wait_on(1, 1'b0, 30);
    wait_on(0, 1'b1, 5);
    rd(8'h20);
    chk(d, 8'h03);
    wr(8'h76, 8'h00);
    wr(8'h73, 8'h00);
    wait_on(0, 1'b0, 100);
    wr(8'h20, 8'h02);
    rd(8'h20);
    chk(d, 8'h00);
    $display("test 5 done");
    give_verdict();
  end
endmodule : reset_watchdog_supervisor_tb

// File: verilog/reset_watchdog_supervisor.sv
// reset output generator and processor watchdog of the supervisor
// assumes violation and critical flags come from comparator logic on clk_i;
// pins (enable, manual reset, strobe, supply comparator) are asynchronous
//
// Function
// - dependent watchdog waits for enable and reset release
// - independent watchdog starts after supply and boot
// - mode bit picks dependent or independent watchdog
// - nonzero startup field adds startup delay
// - every reset event restarts the startup delay, except violation, force and critical resets in independent mode
// - two-bit field selects threshold class
// - polarity bit selects active-low or active-high
// - drive bit selects push-pull or open-drain
// - four-bit field selects reset hold period
// - soft trigger bit forces reset asserted
// - channel select bits gate channel violations
// - reset held one timeout after force clears
// - critical fault channels always assert reset
// - missing strobe edge within timeout flags fault
// - dependent watchdog timer cleared while reset asserted
`timescale 1ns/100ps
module reset_watchdog_supervisor
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int TIME_DIV    = 1
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // register port
  input  wire logic [7:0]              reg_addr_i,
  input  wire logic [7:0]              reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [7:0]              reg_rdata_o,
  // system events
  input  wire logic                    supply_ok_i,
  input  wire logic                    boot_done_i,
  input  wire logic                    soft_reboot_i,
  input  wire logic                    enable_i,
  input  wire logic                    manual_reset_input_n_i,
  input  wire logic                    watchdog_strobe_input_i,
  // monitored channel flags
  input  wire logic [NUM_CHANNELS-1:0] uv_viol_i,
  input  wire logic [NUM_CHANNELS-1:0] ov_viol_i,
  input  wire logic [NUM_CHANNELS-1:0] ew_viol_i,
  input  wire logic [NUM_CHANNELS-1:0] critical_fault_i,
  // outputs
  output logic                         reset_o,
  output logic                         reset_oe_o,
  output logic                         reset_asserted_o,
  output logic                         watchdog_fault_output_n_o
);

  typedef enum {WD_IDLE, WD_START, WD_RUN, WD_FAULT} wd_state_t;

  // ******************************************************************
  // pin synchronisers and time base
  // ******************************************************************
  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic        en_d_r;
  logic        wdi_d_r;
  logic [15:0] presc_r;
  logic [15:0] presc_nxt;
  logic        tick_r;
  logic        tick_nxt;

  // two stages before any logic looks at a pin
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // manual reset pin starts at its idle high level, so no false press
      sync1_r <= 4'h2;
      sync2_r <= 4'h2;
      en_d_r  <= 1'b0;
      wdi_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {supply_ok_i, enable_i, manual_reset_input_n_i, watchdog_strobe_input_i};
      sync2_r <= sync1_r;
      en_d_r  <= sync2_r[2];
      wdi_d_r <= sync2_r[0];
    end
  end

  logic supply_ok_s;
  logic en_s;
  logic mr_act;
  logic wdi_s;
  logic en_rise;
  logic wdi_edge;

  assign supply_ok_s = sync2_r[3];
  assign en_s        = sync2_r[2];
  assign mr_act      = ~sync2_r[1];
  assign wdi_s       = sync2_r[0];
  assign en_rise     = en_s & ~en_d_r;
  assign wdi_edge    = wdi_s ^ wdi_d_r; // either direction counts

  // microsecond tick; long periods count ticks, not cycles
  always_comb
  begin
    tick_nxt  = (presc_r == 16'(TICK_CYCLES - 1));
    presc_nxt = tick_nxt ? 16'h0000 : presc_r + 16'h0001;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      presc_r <= 16'h0000;
      tick_r  <= 1'b0;
    end
    else
    begin
      presc_r <= presc_nxt;
      tick_r  <= tick_nxt;
    end
  end

  // divides a table time for shortened simulation, never below one tick
  function automatic logic [TIME_W-1:0] scale(input logic [TIME_W-1:0] us);
    logic [TIME_W-1:0] q;
    q = us / TIME_W'(TIME_DIV);
    scale = (q == '0) ? TIME_W'(1) : q;
  endfunction : scale

  // ******************************************************************
  // registers
  // ******************************************************************
  logic [7:0] rst_cfg_r, rst_cfg_nxt;
  logic [7:0] sel_lo_r, sel_lo_nxt;
  logic [SEL_HI_W-1:0] sel_hi_r, sel_hi_nxt;
  logic [7:0] wd_mode_r, wd_mode_nxt;
  logic [7:0] wd_cfg_r, wd_cfg_nxt;
  logic       wdrst_flag_r, wdrst_flag_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       reset_act_r;
  logic       wd_rst_r;

  // write decode, readback mux; a watchdog reset sets the flag over a clear
  always_comb
  begin
    rst_cfg_nxt    = rst_cfg_r;
    sel_lo_nxt     = sel_lo_r;
    sel_hi_nxt     = sel_hi_r;
    wd_mode_nxt    = wd_mode_r;
    wd_cfg_nxt     = wd_cfg_r;
    wdrst_flag_nxt = wdrst_flag_r;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        REG_RST_CFG: rst_cfg_nxt = reg_wdata_i;
        REG_SEL_LO:  sel_lo_nxt  = reg_wdata_i;
        REG_SEL_HI:  sel_hi_nxt  = reg_wdata_i[SEL_HI_W-1:0];
        REG_WD_MODE: wd_mode_nxt = reg_wdata_i & (8'h01 << WM_INDEP_BIT);
        REG_WD_CFG:  wd_cfg_nxt  = reg_wdata_i;
        REG_STATUS:  if (reg_wdata_i[ST_WDRST_BIT]) wdrst_flag_nxt = 1'b0;
        default:     ;
      endcase
    end
    if (wd_rst_r)
      wdrst_flag_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_RST_CFG: rdata_nxt = rst_cfg_r;
        REG_SEL_LO:  rdata_nxt = sel_lo_r;
        REG_SEL_HI:  rdata_nxt = {3'b000, sel_hi_r};
        REG_WD_MODE: rdata_nxt = wd_mode_r;
        REG_WD_CFG:  rdata_nxt = wd_cfg_r;
        REG_STATUS:  rdata_nxt = {6'h00, wdrst_flag_r, reset_act_r};
        default:     rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rst_cfg_r    <= RST_CFG_RST;
      sel_lo_r     <= SEL_LO_RST;
      sel_hi_r     <= SEL_HI_RST[SEL_HI_W-1:0];
      wd_mode_r    <= WD_MODE_RST;
      wd_cfg_r     <= WD_CFG_RST;
      wdrst_flag_r <= 1'b0;
      rdata_r      <= 8'h00;
    end
    else
    begin
      rst_cfg_r    <= rst_cfg_nxt;
      sel_lo_r     <= sel_lo_nxt;
      sel_hi_r     <= sel_hi_nxt;
      wd_mode_r    <= wd_mode_nxt;
      wd_cfg_r     <= wd_cfg_nxt;
      wdrst_flag_r <= wdrst_flag_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ******************************************************************
  // reset generation
  // ******************************************************************
  logic [NUM_CHANNELS-1:0] chan_sel;
  logic [NUM_CHANNELS-1:0] class_viol;
  logic                    force_rst;
  logic                    lockout;
  logic                    violation;
  logic                    rst_live;
  logic                    hold_busy;
  logic                    reset_act_nxt;
  logic                    pin_r, pin_nxt;
  logic                    lvl_nxt;
  logic                    oe_r, oe_nxt;

  assign chan_sel  = {sel_hi_r, sel_lo_r[7:1]};
  assign force_rst = sel_lo_r[SEL_FORCE_BIT];
  assign lockout   = ~supply_ok_s | ~boot_done_i;

  // threshold class picks which comparator flags count
  always_comb
  begin
    case (thr_class_t'(rst_cfg_r[RC_CLASS_LSB +: 2]))
      CLASS_UV:   class_viol = uv_viol_i;
      CLASS_EW:   class_viol = ew_viol_i;
      CLASS_OV:   class_viol = ov_viol_i;
      default:    class_viol = uv_viol_i | ov_viol_i;
    endcase
  end

  // critical channels bypass select and class
  assign violation = |(chan_sel & class_viol) | |critical_fault_i;
  assign rst_live  = violation | force_rst | lockout | mr_act | soft_reboot_i | wd_rst_r;

  // hold timer reloads while any cause is live, then runs out the timeout
  tick_timer #(
    .W          (TIME_W)
  ) u_hold (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clr_i      (1'b0),
    .load_i     (rst_live),
    .load_val_i (scale(reset_timeout_us(rst_cfg_r[RC_TMO_LSB +: 4]))),
    .tick_i     (tick_r),
    .busy_o     (hold_busy),
    .expire_o   ()
  );

  // pin level and enable registered together so they never glitch apart
  always_comb
  begin
    reset_act_nxt = rst_live | hold_busy;
    lvl_nxt = rst_cfg_r[RC_POL_BIT] ? reset_act_nxt : ~reset_act_nxt;
    pin_nxt = lvl_nxt & rst_cfg_r[RC_DRIVE_BIT];                  // open drain only pulls low
    oe_nxt  = rst_cfg_r[RC_DRIVE_BIT] | ~lvl_nxt;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reset_act_r <= 1'b1;
      pin_r       <= 1'b0;
      oe_r        <= 1'b1;
    end
    else
    begin
      reset_act_r <= reset_act_nxt;
      pin_r       <= pin_nxt;
      oe_r        <= oe_nxt;
    end
  end

  assign reset_o          = pin_r; // drive gating registered with the level
  assign reset_oe_o       = oe_r;
  assign reset_asserted_o = reset_act_r;

  // ******************************************************************
  // watchdog
  // ******************************************************************
  wd_state_t         wd_state_r, wd_state_nxt;
  logic              wd_fault_r, wd_fault_nxt;
  logic              wd_rst_nxt;
  logic              wd_load;
  logic [TIME_W-1:0] wd_val;
  logic              wd_expire;
  logic              indep;
  logic              wd_enabled;
  logic              wd_allowed;
  logic              restart;
  logic [2:0]        start_code;

  assign indep      = wd_mode_r[WM_INDEP_BIT];
  assign wd_enabled = (wd_cfg_r[WC_TMO_LSB +: 4] != 4'h0);
  assign start_code = wd_cfg_r[WC_START_LSB +: 3];
  assign wd_allowed = indep ? ~lockout : (en_s & ~reset_act_r);
  // dependent mode restarts by going through reset; independent needs the events
  assign restart    = indep & (soft_reboot_i | mr_act | en_rise | wd_rst_r);

  // startup, normal timing and fault; idle holds the timer cleared
  always_comb
  begin
    wd_state_nxt = wd_state_r;
    wd_fault_nxt = wd_fault_r;
    wd_rst_nxt   = 1'b0;
    wd_load      = 1'b0;
    wd_val       = scale(wd_timeout_us(wd_cfg_r[WC_TMO_LSB +: 4]));
    if (~wd_allowed | ~wd_enabled | restart)
    begin
      wd_state_nxt = WD_IDLE;
      wd_fault_nxt = 1'b0;
    end
    else
    begin
      case (wd_state_r)
        WD_IDLE:
        begin
          wd_load = 1'b1;
          if (start_code != 3'h0)
          begin
            wd_val       = scale(startup_delay_us(start_code));
            wd_state_nxt = WD_START;
          end
          else
            wd_state_nxt = WD_RUN;
        end
        WD_START, WD_RUN:
        begin
          if (wdi_edge)
          begin
            wd_load      = 1'b1;
            wd_state_nxt = WD_RUN;
          end
          else if (wd_expire)
          begin
            wd_fault_nxt = 1'b1;
            wd_rst_nxt   = wd_cfg_r[WC_RSTEN_BIT];
            wd_state_nxt = WD_FAULT;
          end
        end
        WD_FAULT:
        begin
          if (wdi_edge)
          begin
            wd_fault_nxt = 1'b0;
            wd_load      = 1'b1;
            wd_state_nxt = WD_RUN;
          end
        end
        default: wd_state_nxt = WD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wd_state_r <= WD_IDLE;
      wd_fault_r <= 1'b0;
      wd_rst_r   <= 1'b0;
    end
    else
    begin
      wd_state_r <= wd_state_nxt;
      wd_fault_r <= wd_fault_nxt;
      wd_rst_r   <= wd_rst_nxt;
    end
  end

  tick_timer #(
    .W          (TIME_W)
  ) u_wd (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .clr_i      (wd_state_nxt == WD_IDLE),
    .load_i     (wd_load),
    .load_val_i (wd_val),
    .tick_i     (tick_r),
    .busy_o     (),
    .expire_o   (wd_expire)
  );

  assign watchdog_fault_output_n_o = ~wd_fault_r;

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wd_timing;
    (wd_state_r == WD_RUN) && wd_allowed && wd_enabled && !restart;
  endsequence
  sequence s_wd_missed;
    wd_expire && !wdi_edge;
  endsequence

  a_dep_wait_reset: assert property (!indep && reset_act_r |=> wd_state_r == WD_IDLE)
    else $error("dependent watchdog active during reset");
  a_dep_clear_tmr: assert property (!indep && reset_act_r |=> !wd_expire && wd_fault_r == 1'b0)
    else $error("dependent watchdog not cleared in reset");
  a_indep_start: assert property (indep && !lockout && wd_enabled && !restart
    && wd_state_r == WD_IDLE |=> wd_state_r != WD_IDLE)
    else $error("independent watchdog did not start");
  a_mode_select: assert property (indep && !lockout && wd_enabled && !restart && reset_act_r
    && wd_state_r == WD_RUN |=> wd_state_r != WD_IDLE)
    else $error("independent watchdog disturbed by reset");
  a_startup_delay: assert property (wd_state_r == WD_IDLE && wd_allowed && wd_enabled && !restart
    |=> wd_state_r == ((start_code == 3'h0) ? WD_RUN : WD_START))
    else $error("wrong startup delay choice");
  a_restart_idle: assert property (restart |=> wd_state_r == WD_IDLE ##1 wd_state_r != WD_FAULT)
    else $error("startup not restarted after reset event");
  a_force_reset: assert property (force_rst |=> reset_act_r [*2])
    else $error("forced reset not asserted");
  a_force_hold: assert property ($fell(force_rst) && hold_busy |-> reset_act_r ##1 reset_act_r)
    else $error("reset dropped right after force cleared");
  a_crit_reset: assert property (|critical_fault_i |=> reset_act_r)
    else $error("critical fault did not assert reset");
  a_wd_fault: assert property (s_wd_timing ##0 s_wd_missed |=> !watchdog_fault_output_n_o)
    else $error("missed strobe did not flag fault");
  a_pin_level: assert property (##1 reset_oe_o == ($past(rst_cfg_r[RC_DRIVE_BIT])
    | !($past(rst_cfg_r[RC_POL_BIT]) ? reset_act_r : !reset_act_r)))
    else $error("reset pin enable wrong");
  a_pin_polarity: assert property (reset_oe_o && $past(rst_cfg_r[RC_DRIVE_BIT])
    |-> reset_o == ($past(rst_cfg_r[RC_POL_BIT]) ? reset_act_r : !reset_act_r))
    else $error("reset pin polarity wrong");
  a_release_idle: assert property (!rst_live && !hold_busy |=> !reset_act_r)
    else $error("reset held with no cause");

endmodule : reset_watchdog_supervisor

// File: verilog/supervisor_pkg.sv
// constants, register map and timing tables of the reset and watchdog supervisor
// assumes a single 50 MHz clock; all times are kept in microseconds
package supervisor_pkg;

  // ******************************************************************
  // clock and time base
  // ******************************************************************
  localparam int CLK_FREQ_HZ     = 50_000_000;
  localparam int HZ_PER_MHZ      = 1_000_000;
  localparam int TICK_PERIOD_US  = 1;
  localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / HZ_PER_MHZ * TICK_PERIOD_US;
  localparam int US_PER_MS       = 1000;
  localparam int US_PER_S        = 1_000_000;
  localparam int NUM_CHANNELS    = 12;
  localparam int TIME_W          = 32;

  // ******************************************************************
  // register offsets
  // ******************************************************************
  localparam logic [7:0] REG_STATUS      = 8'h20;
  localparam logic [7:0] REG_RST_CFG     = 8'h3B;
  localparam logic [7:0] REG_SEL_LO      = 8'h3C;
  localparam logic [7:0] REG_SEL_HI      = 8'h3D;
  localparam logic [7:0] REG_WD_MODE     = 8'h73;
  localparam logic [7:0] REG_WD_CFG      = 8'h76;

  // ******************************************************************
  // field positions and reset values
  // ******************************************************************
  localparam int RC_CLASS_LSB  = 0;
  localparam int RC_POL_BIT    = 2;
  localparam int RC_DRIVE_BIT  = 3;
  localparam int RC_TMO_LSB    = 4;
  localparam int SEL_FORCE_BIT = 0;
  localparam int SEL_HI_W      = 5;
  localparam int WM_INDEP_BIT  = 4;
  localparam int WC_TMO_LSB    = 0;
  localparam int WC_START_LSB  = 4;
  localparam int WC_RSTEN_BIT  = 7;
  localparam int ST_RESET_BIT  = 0;
  localparam int ST_WDRST_BIT  = 1;

  localparam logic [7:0] RST_CFG_RST = 8'h00;
  localparam logic [7:0] SEL_LO_RST  = 8'h00;
  localparam logic [7:0] SEL_HI_RST  = 8'h00;
  localparam logic [7:0] WD_MODE_RST = 8'h00;
  localparam logic [7:0] WD_CFG_RST  = 8'h00;

  // threshold classes that can trigger reset
  typedef enum logic [1:0] {
    CLASS_UV   = 2'b00,
    CLASS_EW   = 2'b01,
    CLASS_OV   = 2'b10,
    CLASS_UVOV = 2'b11
  } thr_class_t;

  // ******************************************************************
  // timing tables, microseconds
  // ******************************************************************
  // codes 1001 and above fall back to the longest known period
  function automatic logic [TIME_W-1:0] reset_timeout_us(input logic [3:0] code);
    case (code)
      4'h0:    reset_timeout_us = 32'd25;
      4'h1:    reset_timeout_us = 32'd1500;
      4'h2:    reset_timeout_us = 32'd2500;
      4'h3:    reset_timeout_us = 32'(4 * US_PER_MS);
      4'h4:    reset_timeout_us = 32'(6 * US_PER_MS);
      4'h5:    reset_timeout_us = 32'(10 * US_PER_MS);
      4'h6:    reset_timeout_us = 32'(15 * US_PER_MS);
      4'h7:    reset_timeout_us = 32'(25 * US_PER_MS);
      4'h8:    reset_timeout_us = 32'(40 * US_PER_MS);
      default: reset_timeout_us = 32'(60 * US_PER_MS);
    endcase
  endfunction : reset_timeout_us

  function automatic logic [TIME_W-1:0] startup_delay_us(input logic [2:0] code);
    case (code)
      3'h1:    startup_delay_us = 32'(30 * US_PER_S);
      3'h2:    startup_delay_us = 32'(40 * US_PER_S);
      3'h3:    startup_delay_us = 32'(80 * US_PER_S);
      3'h4:    startup_delay_us = 32'(120 * US_PER_S);
      3'h5:    startup_delay_us = 32'(160 * US_PER_S);
      3'h6:    startup_delay_us = 32'(220 * US_PER_S);
      3'h7:    startup_delay_us = 32'(300 * US_PER_S);
      default: startup_delay_us = 32'd0;
    endcase
  endfunction : startup_delay_us

  function automatic logic [TIME_W-1:0] wd_timeout_us(input logic [3:0] code);
    case (code)
      4'h1:    wd_timeout_us = 32'(1 * US_PER_MS);
      4'h2:    wd_timeout_us = 32'(2 * US_PER_MS);
      4'h3:    wd_timeout_us = 32'(4 * US_PER_MS);
      4'h4:    wd_timeout_us = 32'(8 * US_PER_MS);
      4'h5:    wd_timeout_us = 32'(14 * US_PER_MS);
      4'h6:    wd_timeout_us = 32'(27 * US_PER_MS);
      4'h7:    wd_timeout_us = 32'(50 * US_PER_MS);
      4'h8:    wd_timeout_us = 32'(100 * US_PER_MS);
      4'h9:    wd_timeout_us = 32'(200 * US_PER_MS);
      4'hA:    wd_timeout_us = 32'(400 * US_PER_MS);
      4'hB:    wd_timeout_us = 32'(750 * US_PER_MS);
      4'hC:    wd_timeout_us = 32'(1400 * US_PER_MS);
      4'hD:    wd_timeout_us = 32'(2700 * US_PER_MS);
      4'hE:    wd_timeout_us = 32'(5 * US_PER_S);
      4'hF:    wd_timeout_us = 32'(10 * US_PER_S);
      default: wd_timeout_us = 32'd0;
    endcase
  endfunction : wd_timeout_us

endpackage : supervisor_pkg

// File: verilog/tick_timer.sv
// down counter that runs on a time-base tick, used for reset hold and watchdog
// assumes tick_i is a one-cycle pulse from logic on the same clock
`timescale 1ns/100ps
module tick_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         clr_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         tick_i,
  // status
  output logic              busy_o,
  output logic              expire_o
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         expire_r;
  logic         expire_nxt;

  // clear wins over load so a held-off timer never restarts by accident
  always_comb
  begin
    count_nxt  = count_r;
    expire_nxt = 1'b0;
    if (clr_i)
      count_nxt = '0;
    else if (load_i)
      count_nxt = load_val_i;
    else if (tick_i && (count_r != '0))
    begin
      count_nxt  = count_r - W'(1);
      expire_nxt = (count_r == W'(1));
    end
  end

  // state registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end
    else
    begin
      count_r  <= count_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign busy_o   = (count_r != '0);
  assign expire_o = expire_r;

endmodule : tick_timer
